//--- ksm_defines.svh
`ifndef KSM_DEFINES_SVH
`define KSM_DEFINES_SVH

// Register byte offsets
`define KSM_OFF_PUSH_TASK   12'h000
`define KSM_OFF_PUSH_DONE   12'h100
`define KSM_OFF_WITHDRAWN   12'h104
`define KSM_OFF_FAULT       12'h108
`define KSM_OFF_IRQ_MASK    12'h300
`define KSM_OFF_IRQ_SET     12'h304
`define KSM_OFF_IRQ_CLR     12'h308
`define KSM_OFF_IRQ_PEND    12'h30c
`define KSM_OFF_STATUS      12'h40c
`define KSM_OFF_SLOT_SEL    12'h500

// Event and enable bit positions
`define KSM_EV_PUSHED       0
`define KSM_EV_WITHDRAWN    1
`define KSM_EV_FAULT        2

// Status bit positions
`define KSM_ST_ACCESS_OK    0
`define KSM_ST_VIOLATION    1

// Reset values and constants
`define KSM_IRQ_MASK_RST    3'h0
`define KSM_SLOT_SEL_RST    8'h00
`define KSM_POISON_WORD     32'hdeaddead
`define KSM_NUM_SLOTS       8'h80
`define KSM_KEY_WORDS       2'h3

`endif

//--- ksm_pkg.sv
package ksm_pkg;

   typedef enum logic [1:0] {
      KSM_IDLE,
      KSM_SETUP,
      KSM_ACCESS
   } ksm_push_state_t;

   typedef struct packed {
      ksm_push_state_t st;
      logic [1:0]      word;
      logic [7:0]      sel;
      logic [2:0]      ev;
      logic [2:0]      en;
      logic            stat_ok;
      logic            stat_blk;
      logic [31:0]     prdata;
      logic            perr;
      logic            m_psel;
      logic            m_penable;
      logic [31:0]     m_paddr;
      logic [31:0]     m_pwdata;
      logic [31:0]     acc_rdata;
      logic            acc_done;
      logic            acc_grant;
   } ksm_state_t;

endpackage : ksm_pkg

//--- ksm_key_slot_manager_regs.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ksm_defines.svh"

// What this block does
// - A push task write sends the selected slot's 128-bit key to its destination over APB.
// - A push that finishes without an error sets the push done event.
// - A push aimed at a revoked slot sets the withdrawn event instead of pushing.
// - A push with no slot, no destination or an error answer sets the fault event.
// - Writing ones to the enable set register enables those events, and it reads the enables.
// - Writing ones to the enable clear register disables those events, and it reads the enables.
// - The pending register shows for each event whether its interrupt is pending.
// - Every write of the slot selector clears the status register.
// - The slot selector names the slot used by key reads and by the push task.
// - The enable mask holds one read/write enable per event and resets to zero.
// - Slots are numbered 1 to 128, and zero, the reset value, selects no slot.
// - A blocked key read returns the fixed poison word.
// - Status flags a good access to the selected slot or a violation otherwise.
module ksm_key_slot_manager_regs #(
   // Slot count and key length in bus words
   parameter int unsigned NUM_SLOTS = 128,
   parameter int unsigned KEY_WORDS = 4
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // APB register slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // Secure APB push master
   output logic              m_psel,
   output logic              m_penable,
   output logic              m_pwrite,
   output logic      [31:0]  m_paddr,
   output logic      [31:0]  m_pwdata,
   input  wire logic         m_pready,
   input  wire logic         m_pslverr,
   // Key storage lookup for the selected slot
   output logic      [7:0]   key_slot_id,
   input  wire logic [127:0] key_value,
   input  wire logic [31:0]  key_dest,
   input  wire logic         key_revoked,
   input  wire logic         key_readable,
   // Key slot access port
   input  wire logic         acc_valid,
   input  wire logic         acc_write,
   input  wire logic [7:0]   acc_slot,
   input  wire logic [1:0]   acc_word,
   output logic      [31:0]  acc_rdata,
   output logic              acc_done,
   output logic              acc_grant,
   // Interrupt
   output logic              irq
);

   ksm_pkg::ksm_state_t s_r;
   ksm_pkg::ksm_state_t s_nxt;

   function automatic logic slot_valid(input logic [7:0] id);
      slot_valid = (id != 8'h00) && (id <= 8'(NUM_SLOTS));
   endfunction : slot_valid

   function automatic logic [31:0] key_word(input logic [127:0] k, input logic [1:0] w);
      key_word = k[{w, 5'h00} +: 32];
   endfunction : key_word

   // Event register offsets, indexed by event bit
   function automatic logic [11:0] ev_offset(input int unsigned idx);
      case (idx)
         `KSM_EV_PUSHED:    ev_offset = `KSM_OFF_PUSH_DONE;
         `KSM_EV_WITHDRAWN: ev_offset = `KSM_OFF_WITHDRAWN;
         default:           ev_offset = `KSM_OFF_FAULT;
      endcase
   endfunction : ev_offset

   // Three views of one enable vector
   function automatic logic [2:0] en_update(input logic [11:0] a,
                                            input logic [2:0]  old,
                                            input logic [2:0]  d);
      logic [2:0] v;
      v = old;
      case (a)
         `KSM_OFF_IRQ_MASK: v = d;
         `KSM_OFF_IRQ_SET:  v = old | d;
         `KSM_OFF_IRQ_CLR:  v = old & ~d;
         default:           v = old;
      endcase
      en_update = v;
   endfunction : en_update

   // Readback mux; unmapped offsets read zero
   function automatic logic [31:0] reg_read(input logic [11:0]         a,
                                            input ksm_pkg::ksm_state_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `KSM_OFF_PUSH_DONE: v = {31'h0, s.ev[`KSM_EV_PUSHED]};
         `KSM_OFF_WITHDRAWN: v = {31'h0, s.ev[`KSM_EV_WITHDRAWN]};
         `KSM_OFF_FAULT:     v = {31'h0, s.ev[`KSM_EV_FAULT]};
         `KSM_OFF_IRQ_MASK, `KSM_OFF_IRQ_SET, `KSM_OFF_IRQ_CLR:
            v = {29'h0, s.en};
         `KSM_OFF_IRQ_PEND:  v = {29'h0, s.ev & s.en};
         `KSM_OFF_STATUS:    v = {30'h0, s.stat_blk, s.stat_ok};
         `KSM_OFF_SLOT_SEL:  v = {24'h0, s.sel};
         default:            v = 32'h0000_0000;
      endcase
      reg_read = v;
   endfunction : reg_read

   // Last word index as the two-bit word counter sees it
   localparam logic [1:0] LAST_WORD = 2'(KEY_WORDS - 1);

   logic setup_ph;
   logic access_ph;
   logic wr_acc;
   logic mapped;
   logic [2:0] set_ev;
   logic push_start;
   logic acc_ok;
   logic [2:0] ev_clr;
   logic [2:0] pend;
   logic no_slot;
   logic no_dest;

   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign wr_acc    = access_ph && pwrite && !s_r.perr;

   // One write-zero clear strobe per event flag
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ev_clr
         assign ev_clr[gi] = wr_acc && (paddr == ev_offset(gi)) && !pwdata[0];
      end
   endgenerate

   // Pending per event, ORed into the one interrupt line
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pend
         assign pend[gi] = s_r.ev[gi] && s_r.en[gi];
      end
   endgenerate

   always_comb begin
      case (paddr)
         `KSM_OFF_PUSH_TASK, `KSM_OFF_PUSH_DONE, `KSM_OFF_WITHDRAWN, `KSM_OFF_FAULT,
         `KSM_OFF_IRQ_MASK, `KSM_OFF_IRQ_SET, `KSM_OFF_IRQ_CLR, `KSM_OFF_IRQ_PEND,
         `KSM_OFF_STATUS, `KSM_OFF_SLOT_SEL: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Task fires on a write of one; ignored while a push is running
   assign push_start = wr_acc && (paddr == `KSM_OFF_PUSH_TASK) && pwdata[0]
                       && (s_r.st == ksm_pkg::KSM_IDLE);

   assign acc_ok = slot_valid(s_r.sel) && (acc_slot == s_r.sel);

   // Push verdicts, taken in priority order
   assign no_slot = !slot_valid(s_r.sel);
   assign no_dest = (key_dest == 32'h0000_0000);

   always_comb begin
      s_nxt  = s_r;
      set_ev = 3'h0;

      // Push sequencer
      case (s_r.st)
         ksm_pkg::KSM_IDLE: begin
            if (push_start) begin
               if (no_slot) begin
                  set_ev[`KSM_EV_FAULT] = 1'b1;
               end else if (key_revoked) begin
                  set_ev[`KSM_EV_WITHDRAWN] = 1'b1;
               end else if (no_dest) begin
                  set_ev[`KSM_EV_FAULT] = 1'b1;
               end else begin
                  s_nxt.st       = ksm_pkg::KSM_SETUP;
                  s_nxt.word     = 2'h0;
                  s_nxt.m_psel   = 1'b1;
                  s_nxt.m_paddr  = key_dest;
                  s_nxt.m_pwdata = key_word(key_value, 2'h0);
               end
            end
         end
         ksm_pkg::KSM_SETUP: begin
            s_nxt.st        = ksm_pkg::KSM_ACCESS;
            s_nxt.m_penable = 1'b1;
         end
         ksm_pkg::KSM_ACCESS: begin
            if (m_pready) begin
               s_nxt.m_penable = 1'b0;
               if (m_pslverr) begin
                  set_ev[`KSM_EV_FAULT] = 1'b1;
                  s_nxt.st     = ksm_pkg::KSM_IDLE;
                  s_nxt.m_psel = 1'b0;
               end else if (s_r.word == LAST_WORD) begin
                  set_ev[`KSM_EV_PUSHED] = 1'b1;
                  s_nxt.st     = ksm_pkg::KSM_IDLE;
                  s_nxt.m_psel = 1'b0;
               end else begin
                  s_nxt.st       = ksm_pkg::KSM_SETUP;
                  s_nxt.word     = s_r.word + 2'h1;
                  s_nxt.m_paddr  = s_r.m_paddr + 32'h0000_0004;
                  s_nxt.m_pwdata = key_word(key_value, s_r.word + 2'h1);
               end
            end
         end
         default: begin
            s_nxt.st        = ksm_pkg::KSM_IDLE;
            s_nxt.m_psel    = 1'b0;
            s_nxt.m_penable = 1'b0;
         end
      endcase

      // Key slot accesses
      s_nxt.acc_done  = acc_valid;
      s_nxt.acc_grant = 1'b0;
      if (acc_valid) begin
         if (acc_ok && (acc_write || (key_readable && !key_revoked))) begin
            s_nxt.stat_ok   = 1'b1;
            s_nxt.acc_grant = 1'b1;
            s_nxt.acc_rdata = acc_write ? 32'h0000_0000 : key_word(key_value, acc_word);
         end else begin
            s_nxt.stat_blk  = 1'b1;
            s_nxt.acc_rdata = acc_write ? 32'h0000_0000 : `KSM_POISON_WORD;
         end
      end

      // Register writes
      if (wr_acc) begin
         case (paddr)
            `KSM_OFF_IRQ_MASK, `KSM_OFF_IRQ_SET, `KSM_OFF_IRQ_CLR: begin
               if (pstrb[0]) s_nxt.en = en_update(paddr, s_r.en, pwdata[2:0]);
            end
            `KSM_OFF_SLOT_SEL: begin
               if (pstrb[0]) s_nxt.sel = pwdata[7:0];
               s_nxt.stat_ok  = 1'b0;
               s_nxt.stat_blk = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // Hardware set beats a clear in the same cycle
      s_nxt.ev = (s_r.ev & ~ev_clr) | set_ev;

      // Read data captured in setup, so access phase answers at once
      if (setup_ph) begin
         s_nxt.perr = !mapped;
         s_nxt.prdata = reg_read(paddr, s_r);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r           <= '0;
         s_r.st        <= ksm_pkg::KSM_IDLE;
         s_r.sel       <= `KSM_SLOT_SEL_RST;
         s_r.en        <= `KSM_IRQ_MASK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata      = s_r.prdata;
   assign pready      = 1'b1;
   assign pslverr     = access_ph && s_r.perr;
   assign m_psel      = s_r.m_psel;
   assign m_penable   = s_r.m_penable;
   assign m_pwrite    = s_r.m_psel;
   assign m_paddr     = s_r.m_paddr;
   assign m_pwdata    = s_r.m_pwdata;
   assign key_slot_id = s_r.sel;
   assign acc_rdata   = s_r.acc_rdata;
   assign acc_done    = s_r.acc_done;
   assign acc_grant   = s_r.acc_grant;
   assign irq         = |pend;

endmodule : ksm_key_slot_manager_regs

//--- ksm_regs_chk.sv
`timescale 1ns/1ps
module ksm_regs_chk (
   // Clock, reset, register bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Push master
   input wire logic        m_psel,
   input wire logic        m_penable,
   input wire logic        m_pready,
   input wire logic [31:0] m_paddr,
   input wire logic [31:0] m_pwdata,
   // Key storage and access
   input wire logic [7:0]  key_slot_id,
   input wire logic [31:0] key_dest,
   input wire logic        key_revoked,
   input wire logic        acc_valid,
   input wire logic        acc_write,
   input wire logic [7:0]  acc_slot,
   input wire logic        acc_done,
   input wire logic        acc_grant,
   input wire logic [31:0] acc_rdata
);
   wire wr  = psel && penable && pwrite;
   wire go  = wr && paddr == 12'h000 && pwdata[0] && !m_psel;
   wire ok  = key_slot_id != 8'h00 && key_slot_id <= 8'h80;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_start;
      go && ok && !key_revoked && key_dest != 32'h0 |=> m_psel && m_paddr == $past(key_dest);
   endproperty
   a_start: assert property (p_start) else $error("push did not start");
   property p_hold;
      m_penable && !m_pready |=> m_penable && $stable(m_paddr) && $stable(m_pwdata);
   endproperty
   a_hold: assert property (p_hold) else $error("push word not held");
   property p_step;
      m_penable && m_pready |=> !m_penable && (!m_psel || m_paddr == $past(m_paddr) + 32'h4);
   endproperty
   a_step: assert property (p_step) else $error("push address step wrong");
   property p_revoked;
      go && key_revoked |=> !m_psel;
   endproperty
   a_revoked: assert property (p_revoked) else $error("revoked slot pushed");
   property p_fault;
      go && (!ok || key_dest == 32'h0) |=> !m_psel;
   endproperty
   a_fault: assert property (p_fault) else $error("bad push started");
   property p_sel;
      $changed(key_slot_id) |-> $past(wr && paddr == 12'h500);
   endproperty
   a_sel: assert property (p_sel) else $error("slot changed unasked");
   property p_done;
      acc_valid |=> acc_done;
   endproperty
   a_done: assert property (p_done) else $error("access not answered");
   property p_deny;
      acc_valid && !acc_write && acc_slot != key_slot_id |=> !acc_grant && acc_rdata == 32'hdeaddead;
   endproperty
   a_deny: assert property (p_deny) else $error("foreign read not blocked");
endmodule : ksm_regs_chk
bind ksm_key_slot_manager_regs ksm_regs_chk ksm_regs_chk_i (.*);

//--- ksm_push_sink.sv
`timescale 1ns/1ps
module ksm_push_sink (
   // Clock
   input wire logic pclk,
   // Secure APB slave side
   input wire logic m_penable,
   input wire logic err,
   output logic     m_pready,
   output logic     m_pslverr
);
   integer seed = 38;
   logic   go   = 1'b0;
   // Random stalls test the hold of each word
   always @(posedge pclk) go <= ($random(seed) & 1) != 0;
   assign m_pready = m_penable && go;
   assign m_pslverr = m_pready && err;
endmodule : ksm_push_sink

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv, err = 0;
   logic [11:0]  paddr = 0, ra[8] = '{12'h100, 12'h104, 12'h108, 12'h300, 12'h304, 12'h308,
                                      12'h30c, 12'h500};
   logic [31:0]  pwdata = 0, prdata, m_paddr, m_pwdata, key_dest = 0, acc_rdata, rd_v, qa[$], qd[$];
   logic [127:0] key_value = 0;
   logic [7:0]   key_slot_id, acc_slot = 0;
   logic [3:0]   pstrb = 4'hf;
   logic [1:0]   acc_word = 0;
   logic pready, pslverr, m_psel, m_penable, m_pwrite, m_pready, m_pslverr, key_revoked = 0;
   logic key_readable = 1, acc_valid = 0, acc_write = 0, acc_done, acc_grant, irq;
   int bad_count = 0, total_checks = 0, cyc = 0, seed = 38, m_en, m_ev;
   ksm_key_slot_manager_regs ksm_key_slot_manager_regs_i (.*);
   ksm_push_sink ksm_push_sink_i (.*);
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (m_psel && m_penable && m_pready) begin
         qa.push_back(m_paddr);
         qd.push_back(m_pwdata);
         `CHK("m_pwrite", 1'b1, m_pwrite)
      end
      if (cyc > 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v = prdata;
      slv = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rd_v)
   endtask : rd
   task automatic acc(input logic [7:0] s, input logic w, input logic g);
      logic [1:0]  wd;
      logic [31:0] e;
      wd = 2'($random(seed));
      e = w ? 32'h0 : g ? key_value[wd * 32 +: 32] : 32'hdeaddead;
      @(posedge pclk);
      {acc_valid, acc_write, acc_slot, acc_word} <= {1'b1, w, s, wd};
      @(posedge pclk);
      acc_valid <= 1'b0;
      @(negedge pclk);
      `CHK("acc_done", 1'b1, acc_done)
      `CHK("acc_grant", g, acc_grant)
      `CHK("acc_rdata", e, acc_rdata)
   endtask : acc
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) rd(ra[i], 32'h0);
      $display("test reset done");
      m_en = $random(seed) & 7;
      apb(1, 12'h300, m_en);
      rd(12'h304, m_en);
      apb(1, 12'h304, 32'h5);
      m_en |= 5;
      rd(12'h308, m_en);
      apb(1, 12'h308, 32'h3);
      m_en &= 4;
      rd(12'h300, m_en);
      apb(1, 12'h200, 32'h7);
      `CHK("pslverr", 1'b1, slv)
      apb(1, 12'h304, 32'h7);
      m_en = 7;
      $display("test enables done");
      for (int c = 0; c < 5; c++) begin
         key_value <= {$random(seed), $random(seed), $random(seed), $random(seed)};
         key_dest <= (c == 2) ? 32'h0 : {$random(seed)} & 32'hfffffff0 | 32'h10;
         key_revoked <= (c == 1);
         err <= (c == 3);
         qa.delete();
         qd.delete();
         apb(1, 12'h500, (c == 4) ? 32'h0 : 32'h5);
         apb(1, 12'h000, 32'h1);
         while (irq !== 1'b1) @(posedge pclk);
         m_ev = (c == 0) ? 1 : (c == 1) ? 2 : 4;
         rd(12'h30c, m_ev & m_en);
         for (int e = 0; e < 3; e++) rd(12'h100 + 12'(e * 4), (m_ev >> e) & 1);
         `CHK("words", (c == 0) ? 4 : (c == 3) ? 1 : 0, qa.size())
         foreach (qa[i]) begin
            `CHK("addr", key_dest + 32'(i * 4), qa[i])
            `CHK("data", key_value[i * 32 +: 32], qd[i])
         end
         for (int e = 0; e < 3; e++) apb(1, 12'h100 + 12'(e * 4), 32'h0);
         @(posedge pclk);
         `CHK("irq", 1'b0, irq)
      end
      $display("test push done");
      {key_revoked, err} <= 2'b00;
      apb(1, 12'h500, 32'h5);
      acc(8'h05, 1'b0, 1'b1);
      rd(12'h40c, 32'h1);
      acc(8'h06, 1'b0, 1'b0);
      rd(12'h40c, 32'h3);
      apb(1, 12'h500, 32'h5);
      rd(12'h40c, 32'h0);
      key_readable <= 1'b0;
      acc(8'h05, 1'b0, 1'b0);
      acc(8'h05, 1'b1, 1'b1);
      rd(12'h40c, 32'h3);
      $display("test access done");
      end_of_test();
   end
endmodule : tb
